/* design/bus_watch.sv */
// Bus-watch comparators A, B and C with range pairing and register port
//
// The strobed register port and the placing of the registers were decided locally.
`include "bus_watch_cfg.svh"
module bus_watch
  import bus_watch_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  input  wire logic                   i_clk_en,
  input  wire logic [`REG_ADDR_W-1:0] i_reg_addr,
  input  wire logic [`REG_DATA_W-1:0] i_reg_wdata,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  output logic      [`REG_DATA_W-1:0] o_reg_rdata,
  input  wire logic                   i_bus_valid,
  input  wire logic [`BUS_ADDR_W-1:0] i_bus_addr,
  input  wire logic [`BUS_DATA_W-1:0] i_bus_data,
  input  wire logic                   i_bus_rnw,
  input  wire logic                   i_bus_byte,
  input  wire logic                   i_background_debug_state,
  input  wire logic                   i_background_debug_access,
  output logic      [2:0]             o_force_match,
  output logic      [2:0]             o_tag_match,
  output logic      [2:0]             o_break_req
);

  watch_state_t st;
  watch_state_t next_st;

  logic [2:0] eq;
  logic [2:0] below;
  logic [2:0] above;
  logic [2:0] below_word;
  logic [2:0] above_word;
  logic [2:0] dir_ok;
  logic [2:0] size_ok;
  logic [2:0] single_hit;
  logic       data_ok;
  logic       range_on;
  logic       range_in;
  logic       range_out;
  logic       range_hit;
  logic       bus_live;
  logic [2:0] hit;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator channels
  generate
    for (genvar g = 0; g < 3; g++) begin : g_chan
      addr_comparator #(
        .HAS_SIZE (g < 2)
      ) u_cmp (
        .i_ref_addr   (st.ref_addr[g]),
        .i_bus_addr   (i_bus_addr),
        .i_ctrl       (st.ctrl[g]),
        .i_bus_rnw    (i_bus_rnw),
        .i_bus_byte   (i_bus_byte),
        .o_eq         (eq[g]),
        .o_below      (below[g]),
        .o_above      (above[g]),
        .o_below_word (below_word[g]),
        .o_above_word (above_word[g]),
        .o_dir_ok     (dir_ok[g]),
        .o_size_ok    (size_ok[g])
      );
      // Tagged match: exact opcode address, qualifiers ignored
      if (g == 0) begin : g_data
        assign single_hit[g] = eq[g] && (st.ctrl[g].opcode_qualify_select ||
                               (dir_ok[g] && size_ok[g] && data_ok));
      end else begin : g_plain
        assign single_hit[g] = eq[g] && (st.ctrl[g].opcode_qualify_select ||
                               (dir_ok[g] && size_ok[g]));
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Data compare: bus[15:8] is the lower-address byte against the high value
  logic [`BUS_DATA_W-1:0] data_diff;
  assign data_diff = (i_bus_data ^ st.data_cmp) & st.data_mask;
  // Byte accesses with an unqualified size may hit by accident on the low half
  assign data_ok = st.ctrl[0].data_not_equal_select ? (data_diff != `RST_DATA)
                                                    : (data_diff == `RST_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // Range pairing: only both enables together turn it on
  assign range_on  = st.range_cfg.range_low_enable && st.range_cfg.range_high_enable;
  assign range_in  = st.ctrl[0].opcode_qualify_select ?
                     (!below_word[0] && !above_word[1]) : (!below[0] && !above[1]);
  assign range_out = st.ctrl[0].opcode_qualify_select ?
                     (below_word[0] || above_word[1]) : (below[0] || above[1]);
  // A's data and direction qualify unless A is tagged; sizes and all of B's bits are ignored
  assign range_hit = (st.range_cfg.range_outside_select ? range_out : range_in) &&
                     (st.ctrl[0].opcode_qualify_select || (dir_ok[0] && data_ok));

  assign bus_live = i_bus_valid && !i_background_debug_state && !i_background_debug_access;

  always_comb begin
    hit[0] = bus_live && (range_on ? range_hit : single_hit[0]);
    hit[1] = bus_live && !range_on && single_hit[1];
    hit[2] = bus_live && single_hit[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rd_data = `RST_RD_DATA;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `OFS_REF_ADDR_A: begin
          next_st.ref_addr[0] = i_reg_wdata[`BUS_ADDR_W-1:0];
        end
        `OFS_REF_ADDR_B: begin
          next_st.ref_addr[1] = i_reg_wdata[`BUS_ADDR_W-1:0];
        end
        `OFS_REF_ADDR_C: begin
          next_st.ref_addr[2] = i_reg_wdata[`BUS_ADDR_W-1:0];
        end
        `OFS_CTRL_A: begin
          next_st.ctrl[0] = i_reg_wdata[`CTRL_W-1:0];
        end
        `OFS_CTRL_B: begin
          next_st.ctrl[1] = i_reg_wdata[`CTRL_W-1:0];
        end
        `OFS_CTRL_C: begin
          next_st.ctrl[2] = i_reg_wdata[`CTRL_W-1:0];
        end
        `OFS_DATA_CMP: begin
          next_st.data_cmp = i_reg_wdata[`BUS_DATA_W-1:0];
        end
        `OFS_DATA_MASK: begin
          next_st.data_mask = i_reg_wdata[`BUS_DATA_W-1:0];
        end
        `OFS_RANGE_CFG: begin
          next_st.range_cfg = i_reg_wdata[`RANGE_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `OFS_REF_ADDR_A: next_st.rd_data = {14'h0000, st.ref_addr[0]};
        `OFS_REF_ADDR_B: next_st.rd_data = {14'h0000, st.ref_addr[1]};
        `OFS_REF_ADDR_C: next_st.rd_data = {14'h0000, st.ref_addr[2]};
        `OFS_CTRL_A:     next_st.rd_data = {25'h0000000, st.ctrl[0]};
        `OFS_CTRL_B:     next_st.rd_data = {25'h0000000, st.ctrl[1]};
        `OFS_CTRL_C:     next_st.rd_data = {25'h0000000, st.ctrl[2]};
        `OFS_DATA_CMP:   next_st.rd_data = {16'h0000, st.data_cmp};
        `OFS_DATA_MASK:  next_st.rd_data = {16'h0000, st.data_mask};
        `OFS_RANGE_CFG:  next_st.rd_data = {29'h00000000, st.range_cfg};
        `OFS_MATCH_STAT: next_st.rd_data = {23'h000000, st.break_req, st.tag_match, st.force_match};
        default:         next_st.rd_data = `RST_RD_DATA;
      endcase
    end
    // Mode bit routes each hit to forced or tagged output
    for (int c = 0; c < 3; c++) begin
      next_st.force_match[c] = hit[c] && !st.ctrl[c].opcode_qualify_select;
      next_st.tag_match[c]   = hit[c] && st.ctrl[c].opcode_qualify_select;
      next_st.break_req[c]   = hit[c] && st.ctrl[c].breakpoint_on_match;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st.ref_addr    <= {3{`RST_REF_ADDR}};
      st.ctrl        <= {3{`RST_CTRL}};
      st.data_cmp    <= `RST_DATA;
      st.data_mask   <= `RST_DATA;
      st.range_cfg   <= `RST_RANGE;
      st.rd_data     <= `RST_RD_DATA;
      st.force_match <= `RST_MATCH;
      st.tag_match   <= `RST_MATCH;
      st.break_req   <= `RST_MATCH;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_reg_rdata   = st.rd_data;
  assign o_force_match = st.force_match;
  assign o_tag_match   = st.tag_match;
  assign o_break_req   = st.break_req;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  logic [`BUS_ADDR_W-1:0] addr_lo;
  logic [`BUS_ADDR_W-1:0] addr_hi;
  assign addr_lo = st.ref_addr[0];
  assign addr_hi = st.ref_addr[1];

  chk_debug_state_quiet: assert property (
    i_clk_en && (i_background_debug_state || i_background_debug_access) |=>
    (o_force_match == 3'h0) && (o_tag_match == 3'h0))
    else $error("match during background debug");

  chk_c_exact_only: assert property (
    i_clk_en && (i_bus_addr != st.ref_addr[2]) |=> !o_force_match[2] && !o_tag_match[2])
    else $error("comparator C hit on other address");

  chk_c_dir_write: assert property (
    i_clk_en && bus_live && (i_bus_addr == st.ref_addr[2]) && !st.ctrl[2].opcode_qualify_select &&
    (!st.ctrl[2].direction_qualify_enable || (st.ctrl[2].direction_select == i_bus_rnw))
    |=> o_force_match[2])
    else $error("comparator C missed qualified access");

  chk_b_dir_block: assert property (
    i_clk_en && !st.ctrl[1].opcode_qualify_select && st.ctrl[1].direction_qualify_enable &&
    (st.ctrl[1].direction_select != i_bus_rnw) && !range_on |=> !o_force_match[1])
    else $error("comparator B ignored direction");

  chk_a_size_block: assert property (
    i_clk_en && !range_on && !st.ctrl[0].opcode_qualify_select && st.ctrl[0].size_qualify_enable &&
    (st.ctrl[0].size_select != i_bus_byte) |=> !o_force_match[0])
    else $error("comparator A ignored size");

  chk_differ_no_mask: assert property (
    i_clk_en && !range_on && !st.ctrl[0].opcode_qualify_select && st.ctrl[0].data_not_equal_select &&
    (st.data_mask == 16'h0000) |=> !o_force_match[0])
    else $error("difference match with empty mask");

  chk_range_b_idle: assert property (
    i_clk_en && range_on |=> (o_force_match[1] == 1'b0) && (o_tag_match[1] == 1'b0) && !o_break_req[1])
    else $error("channel B active in range mode");

  chk_inside_hit: assert property (
    i_clk_en && bus_live && range_on && !st.range_cfg.range_outside_select &&
    !st.ctrl[0].opcode_qualify_select && !st.ctrl[0].direction_qualify_enable &&
    !st.ctrl[0].data_not_equal_select && (addr_lo <= i_bus_addr) && (i_bus_addr <= addr_hi) &&
    ((i_bus_data & st.data_mask) == (st.data_cmp & st.data_mask)) |=> o_force_match[0])
    else $error("inside range missed");

  chk_outside_miss: assert property (
    i_clk_en && range_on && st.range_cfg.range_outside_select && !st.ctrl[0].opcode_qualify_select &&
    (addr_lo <= i_bus_addr) && (i_bus_addr <= addr_hi) |=> !o_force_match[0])
    else $error("outside range hit inside");

  chk_tag_exact: assert property (
    i_clk_en && bus_live && !range_on && st.ctrl[0].opcode_qualify_select &&
    (i_bus_addr == st.ref_addr[0]) |=> o_tag_match[0] && !o_force_match[0])
    else $error("tagged match not on exact address");

  chk_b_size_block: assert property (
    i_clk_en && !range_on && !st.ctrl[1].opcode_qualify_select && st.ctrl[1].size_qualify_enable &&
    (st.ctrl[1].size_select != i_bus_byte) |=> !o_force_match[1])
    else $error("comparator B ignored size");

  chk_c_dir_block: assert property (
    i_clk_en && !st.ctrl[2].opcode_qualify_select && st.ctrl[2].direction_qualify_enable &&
    (st.ctrl[2].direction_select != i_bus_rnw) |=> !o_force_match[2])
    else $error("comparator C ignored direction");

  chk_a_plain_hit: assert property (
    i_clk_en && bus_live && !range_on && (st.ctrl[0][6:2] == 5'h00) && !st.ctrl[0].opcode_qualify_select &&
    (st.data_mask == 16'h0000) && (i_bus_addr == st.ref_addr[0]) |=> o_force_match[0])
    else $error("comparator A missed address-only match");

  chk_high_byte_hit: assert property (
    i_clk_en && bus_live && !range_on && (st.ctrl[0][6:2] == 5'h00) && !st.ctrl[0].opcode_qualify_select &&
    (st.data_mask == 16'hff00) && (i_bus_addr == st.ref_addr[0]) && (i_bus_data[15:8] == st.data_cmp[15:8])
    |=> o_force_match[0])
    else $error("lower-address byte match missed");

  chk_low_byte_hit: assert property (
    i_clk_en && bus_live && !range_on && (st.ctrl[0][6:2] == 5'h00) && !st.ctrl[0].opcode_qualify_select &&
    (st.data_mask == 16'h00ff) && (i_bus_addr == st.ref_addr[0]) && (i_bus_data[7:0] == st.data_cmp[7:0])
    |=> o_force_match[0])
    else $error("upper-address byte match missed");

  chk_equal_mismatch: assert property (
    i_clk_en && !range_on && !st.ctrl[0].opcode_qualify_select && !st.ctrl[0].data_not_equal_select &&
    ((i_bus_data & st.data_mask) != (st.data_cmp & st.data_mask)) |=> !o_force_match[0])
    else $error("equal mode hit on differing data");

  chk_differ_hit: assert property (
    i_clk_en && bus_live && !range_on && (st.ctrl[0][5:2] == 4'h0) && !st.ctrl[0].opcode_qualify_select &&
    st.ctrl[0].data_not_equal_select && (i_bus_addr == st.ref_addr[0]) &&
    ((i_bus_data & st.data_mask) != (st.data_cmp & st.data_mask)) |=> o_force_match[0])
    else $error("difference mode missed");

  chk_range_dir_block: assert property (
    i_clk_en && range_on && !st.ctrl[0].opcode_qualify_select && st.ctrl[0].direction_qualify_enable &&
    (st.ctrl[0].direction_select != i_bus_rnw) |=> !o_force_match[0])
    else $error("range ignored direction of A");

  chk_range_break_a: assert property (
    i_clk_en && range_on && !st.ctrl[0].breakpoint_on_match |=> !o_break_req[0])
    else $error("range break without A enable");

  chk_b_single_hit: assert property (
    i_clk_en && bus_live && !range_on && !st.ctrl[1].opcode_qualify_select &&
    !st.ctrl[1].direction_qualify_enable && !st.ctrl[1].size_qualify_enable &&
    (i_bus_addr == st.ref_addr[1]) |=> o_force_match[1])
    else $error("comparator B missed single match");

  chk_tag_range_word: assert property (
    i_clk_en && bus_live && range_on && !st.range_cfg.range_outside_select && st.ctrl[0].opcode_qualify_select &&
    (i_bus_addr[17:1] >= addr_lo[17:1]) && (i_bus_addr[17:1] <= addr_hi[17:1]) |=> o_tag_match[0])
    else $error("tagged range missed word");

  chk_outside_hit: assert property (
    i_clk_en && bus_live && range_on && st.range_cfg.range_outside_select && (st.ctrl[0][6:3] == 4'h0) &&
    !st.ctrl[0].opcode_qualify_select && (st.data_mask == 16'h0000) &&
    ((i_bus_addr < addr_lo) || (i_bus_addr > addr_hi)) |=> o_force_match[0])
    else $error("outside range missed");

  chk_inside_miss: assert property (
    i_clk_en && range_on && !st.range_cfg.range_outside_select && !st.ctrl[0].opcode_qualify_select &&
    ((i_bus_addr < addr_lo) || (i_bus_addr > addr_hi)) |=> !o_force_match[0])
    else $error("inside range hit outside");

  chk_c_tag_mode: assert property (
    i_clk_en && bus_live && st.ctrl[2].opcode_qualify_select && (i_bus_addr == st.ref_addr[2])
    |=> o_tag_match[2] && !o_force_match[2])
    else $error("comparator C mode routing wrong");

  chk_debug_break_quiet: assert property (
    i_clk_en && (i_background_debug_state || i_background_debug_access) |=> (o_break_req == 3'h0))
    else $error("break during background debug");

  chk_rdata_slot: assert property (
    i_clk_en && !i_reg_rd |=> (o_reg_rdata == 32'h00000000))
    else $error("read data outside its slot");

  cov_c_match: cover property (i_clk_en && bus_live ##1 o_force_match[2]);
  cov_inside: cover property (range_on && !st.range_cfg.range_outside_select ##1 o_force_match[0]);
  cov_outside: cover property (range_on && st.range_cfg.range_outside_select ##1 o_force_match[0]);
  cov_differ_hit: cover property (st.ctrl[0].data_not_equal_select && !range_on ##1 o_force_match[0]);
  cov_tag: cover property (o_tag_match != 3'h0);

endmodule

/* design/bus_watch_cfg.svh */
// Offsets, widths and reset values of the bus-watch comparators
`ifndef BUS_WATCH_CFG_SVH
`define BUS_WATCH_CFG_SVH

`define BUS_ADDR_W       18
`define BUS_DATA_W       16
`define REG_ADDR_W       8
`define REG_DATA_W       32

`define OFS_REF_ADDR_A   8'h00
`define OFS_REF_ADDR_B   8'h04
`define OFS_REF_ADDR_C   8'h08
`define OFS_CTRL_A       8'h0c
`define OFS_CTRL_B       8'h10
`define OFS_CTRL_C       8'h14
`define OFS_DATA_CMP     8'h18
`define OFS_DATA_MASK    8'h1c
`define OFS_RANGE_CFG    8'h20
`define OFS_MATCH_STAT   8'h24

`define CTRL_W           7
`define RANGE_W          3

`define RST_REF_ADDR     18'h00000
`define RST_CTRL         7'h00
`define RST_DATA         16'h0000
`define RST_RANGE        3'h0
`define RST_MATCH        3'h0
`define RST_RD_DATA      32'h00000000

`endif

/* design/bus_watch_pkg.sv */
// Types shared by the bus-watch comparator design
package bus_watch_pkg;
`include "bus_watch_cfg.svh"

  // Control word of one comparator, msb first
  typedef struct packed {
    logic data_not_equal_select;
    logic size_qualify_enable;
    logic size_select;
    logic direction_qualify_enable;
    logic direction_select;
    logic breakpoint_on_match;
    logic opcode_qualify_select;
  } chan_ctrl_t;

  typedef struct packed {
    logic range_outside_select;
    logic range_high_enable;
    logic range_low_enable;
  } range_cfg_t;

  typedef struct packed {
    logic [2:0][`BUS_ADDR_W-1:0] ref_addr;
    chan_ctrl_t [2:0]            ctrl;
    logic [`BUS_DATA_W-1:0]      data_cmp;
    logic [`BUS_DATA_W-1:0]      data_mask;
    range_cfg_t                  range_cfg;
    logic [`REG_DATA_W-1:0]      rd_data;
    logic [2:0]                  force_match;
    logic [2:0]                  tag_match;
    logic [2:0]                  break_req;
  } watch_state_t;

endpackage

/* design/addr_comparator.sv */
// One address comparator: exact, word-level and ordering compares plus access qualifiers
`include "bus_watch_cfg.svh"
module addr_comparator
  import bus_watch_pkg::*;
#(
  parameter bit HAS_SIZE = 1'b1
) (
  input  wire logic [`BUS_ADDR_W-1:0] i_ref_addr,
  input  wire logic [`BUS_ADDR_W-1:0] i_bus_addr,
  input  wire chan_ctrl_t             i_ctrl,
  input  wire logic                   i_bus_rnw,
  input  wire logic                   i_bus_byte,
  output logic                        o_eq,
  output logic                        o_below,
  output logic                        o_above,
  output logic                        o_below_word,
  output logic                        o_above_word,
  output logic                        o_dir_ok,
  output logic                        o_size_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // Exact compare only; a word at n-1 never hits n
  assign o_eq         = (i_bus_addr == i_ref_addr);
  assign o_below      = (i_bus_addr < i_ref_addr);
  assign o_above      = (i_bus_addr > i_ref_addr);
  // Tagged ranges resolve only to word boundaries
  assign o_below_word = (i_bus_addr[`BUS_ADDR_W-1:1] < i_ref_addr[`BUS_ADDR_W-1:1]);
  assign o_above_word = (i_bus_addr[`BUS_ADDR_W-1:1] > i_ref_addr[`BUS_ADDR_W-1:1]);

  ////////////////////////////////////////////////////////////////////////////
  assign o_dir_ok  = !i_ctrl.direction_qualify_enable ||
                     (i_ctrl.direction_select == i_bus_rnw);
  // Channel without size controls always accepts any size
  assign o_size_ok = !HAS_SIZE || !i_ctrl.size_qualify_enable ||
                     (i_ctrl.size_select == i_bus_byte);

endmodule

/* test/cpu_bus_model.sv */
// Processor bus model: one bus cycle per request, scrambled lines while idle
module cpu_bus_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_go,
  input  wire logic [17:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic        i_rnw,
  input  wire logic        i_byte,
  output logic             o_bus_valid,
  output logic      [17:0] o_bus_addr,
  output logic      [15:0] o_bus_data,
  output logic             o_bus_rnw,
  output logic             o_bus_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] last_addr = 18'h00000;
  logic [15:0] noise     = 16'h0000;
  // Idle lines never keep a stale value, so leftovers cannot fake a hit
  always_ff @(posedge i_clk_sys) begin
    noise <= noise + 16'h9e37;
    if (i_go) begin
      last_addr <= i_addr;
    end
  end
  assign o_bus_valid = i_go;
  assign o_bus_addr  = i_go ? i_addr : ~last_addr;
  assign o_bus_data  = i_go ? i_data : noise;
  assign o_bus_rnw   = i_go ? i_rnw : noise[0];
  assign o_bus_byte  = i_go ? i_byte : noise[1];
endmodule

/* test/bus_watch_tb.sv */
// Self-checking bench for the bus-watch comparators
module bus_watch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys   = 1'b0;
  logic        reset     = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] rdata;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        go        = 1'b0;
  logic        rnw       = 1'b0;
  logic        byt       = 1'b0;
  logic        bg_state  = 1'b0;
  logic        bg_access = 1'b0;
  logic        clk_en    = 1'b1;
  logic [17:0] addr      = 18'h00000;
  logic [15:0] data      = 16'h0000;
  logic [17:0] bus_addr;
  logic [15:0] bus_data;
  logic        bus_valid;
  logic        bus_rnw;
  logic        bus_byte;
  logic [2:0]  fm;
  logic [2:0]  tm;
  logic [2:0]  bk;
  int          miscompares = 0;
  int          cmp_count   = 0;
  ////////////////////////////////////////
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  cpu_bus_model cpu_bus_model_i (
    .i_clk_sys(clk_sys), .i_go(go), .i_addr(addr), .i_data(data), .i_rnw(rnw), .i_byte(byt),
    .o_bus_valid(bus_valid), .o_bus_addr(bus_addr), .o_bus_data(bus_data), .o_bus_rnw(bus_rnw),
    .o_bus_byte(bus_byte));
  bus_watch bus_watch_i (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_clk_en(clk_en), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
    .i_bus_valid(bus_valid), .i_bus_addr(bus_addr), .i_bus_data(bus_data), .i_bus_rnw(bus_rnw),
    .i_bus_byte(bus_byte), .i_background_debug_state(bg_state), .i_background_debug_access(bg_access),
    .o_force_match(fm), .o_tag_match(tm), .o_break_req(bk));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", exp, rdata);
  endtask
  task automatic cfg(input logic [6:0] ca, cb, cc, input logic [15:0] mask, input logic [2:0] rng);
    wr(8'h0c, {25'h0000000, ca});
    wr(8'h10, {25'h0000000, cb});
    wr(8'h14, {25'h0000000, cc});
    wr(8'h1c, {16'h0000, mask});
    wr(8'h20, {29'h00000000, rng});
  endtask
  // Kind bits: read, byte, debug state, debug access; expect nibbles force, tag, break
  task automatic hit(input logic [17:0] a, input logic [15:0] d, input logic [3:0] kind, input logic [11:0] exp);
    @(posedge clk_sys);
    {go, addr, data, rnw, byt, bg_state, bg_access} <= {1'b1, a, d, kind};
    @(posedge clk_sys);
    {go, bg_state, bg_access} <= 3'h0;
    #1 check("match_out", {20'h00000, exp}, {21'h000000, fm, 1'b0, tm, 1'b0, bk});
    @(posedge clk_sys);
    #1 check("match_idle", 32'h00000000, {21'h000000, fm, 1'b0, tm, 1'b0, bk});
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #100us;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h0c, 32'h00000000);
    rd(8'h20, 32'h00000000);
    wr(8'h00, 32'h00000100);
    wr(8'h04, 32'h00000200);
    wr(8'h08, 32'h00000300);
    wr(8'h18, 32'h00005aa5);
    rd(8'h08, 32'h00000300);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0000007f);
    wr(8'h24, 32'hffffffff);
    rd(8'h24, 32'h00000000);
    rd(8'h30, 32'h00000000);
    cfg(7'h00, 7'h00, 7'h00, 16'h0000, 3'h0);
    hit(18'h00300, 16'h0000, 4'h0, 12'h400);
    hit(18'h002ff, 16'h0000, 4'h0, 12'h000);
    hit(18'h00200, 16'h0000, 4'hc, 12'h200);
    hit(18'h00100, 16'h1234, 4'h0, 12'h100);
    hit(18'h00300, 16'h0000, 4'h2, 12'h000);
    hit(18'h00300, 16'h0000, 4'h1, 12'h000);
    cfg(7'h00, 7'h0c, 7'h08, 16'h0000, 3'h0);
    hit(18'h00300, 16'h0000, 4'h8, 12'h000);
    hit(18'h00300, 16'h0000, 4'h0, 12'h400);
    hit(18'h00200, 16'h0000, 4'h8, 12'h200);
    hit(18'h00200, 16'h0000, 4'h0, 12'h000);
    cfg(7'h00, 7'h30, 7'h0c, 16'h0000, 3'h0);
    hit(18'h00300, 16'h0000, 4'h8, 12'h400);
    hit(18'h00300, 16'h0000, 4'h0, 12'h000);
    hit(18'h00200, 16'h0000, 4'h0, 12'h000);
    hit(18'h00200, 16'h0000, 4'h4, 12'h200);
    cfg(7'h00, 7'h20, 7'h02, 16'h0000, 3'h0);
    hit(18'h00200, 16'h0000, 4'h4, 12'h000);
    hit(18'h00300, 16'h0000, 4'h0, 12'h404);
    cfg(7'h00, 7'h03, 7'h09, 16'hff00, 3'h0);
    hit(18'h00200, 16'h0000, 4'h0, 12'h022);
    hit(18'h00300, 16'h0000, 4'h8, 12'h040);
    hit(18'h00100, 16'h5a00, 4'h0, 12'h100);
    hit(18'h00100, 16'ha500, 4'h0, 12'h000);
    hit(18'h00100, 16'h5aff, 4'h0, 12'h100);
    cfg(7'h00, 7'h00, 7'h00, 16'h00ff, 3'h0);
    hit(18'h00100, 16'h00a5, 4'h0, 12'h100);
    hit(18'h00100, 16'h5a5a, 4'h0, 12'h000);
    cfg(7'h00, 7'h00, 7'h00, 16'hffff, 3'h0);
    hit(18'h00100, 16'h5aa5, 4'h0, 12'h100);
    hit(18'h00100, 16'h5aa4, 4'h0, 12'h000);
    cfg(7'h40, 7'h00, 7'h00, 16'hffff, 3'h0);
    hit(18'h00100, 16'h5aa5, 4'h0, 12'h000);
    hit(18'h00100, 16'h5aa4, 4'h0, 12'h100);
    cfg(7'h40, 7'h00, 7'h00, 16'h0000, 3'h0);
    hit(18'h00100, 16'h5aa4, 4'h0, 12'h000);
    cfg(7'h01, 7'h00, 7'h00, 16'hffff, 3'h0);
    hit(18'h00100, 16'h0000, 4'hc, 12'h010);
    cfg(7'h00, 7'h08, 7'h00, 16'h0000, 3'h3);
    hit(18'h00180, 16'h0000, 4'h8, 12'h100);
    hit(18'h00100, 16'h0000, 4'h0, 12'h100);
    hit(18'h00200, 16'h0000, 4'h0, 12'h100);
    hit(18'h000ff, 16'h0000, 4'h0, 12'h000);
    hit(18'h00201, 16'h0000, 4'h0, 12'h000);
    cfg(7'h30, 7'h02, 7'h00, 16'h0000, 3'h3);
    hit(18'h00180, 16'h0000, 4'h0, 12'h100);
    cfg(7'h0a, 7'h00, 7'h00, 16'h0000, 3'h3);
    hit(18'h00180, 16'h0000, 4'h8, 12'h000);
    hit(18'h00180, 16'h0000, 4'h0, 12'h101);
    cfg(7'h00, 7'h00, 7'h00, 16'hffff, 3'h3);
    hit(18'h00180, 16'h0000, 4'h0, 12'h000);
    hit(18'h00180, 16'h5aa5, 4'h0, 12'h100);
    cfg(7'h01, 7'h00, 7'h00, 16'h0000, 3'h3);
    hit(18'h00201, 16'h0000, 4'h0, 12'h010);
    hit(18'h00180, 16'h0000, 4'h0, 12'h010);
    cfg(7'h00, 7'h01, 7'h00, 16'h0000, 3'h7);
    hit(18'h000ff, 16'h0000, 4'h0, 12'h100);
    hit(18'h00201, 16'h0000, 4'h0, 12'h100);
    hit(18'h00180, 16'h0000, 4'h0, 12'h000);
    hit(18'h00200, 16'h0000, 4'h0, 12'h000);
    cfg(7'h00, 7'h00, 7'h00, 16'h0000, 3'h1);
    hit(18'h00180, 16'h0000, 4'h0, 12'h000);
    hit(18'h00200, 16'h0000, 4'h0, 12'h200);
    wr(8'h04, 32'h0003ffff);
    cfg(7'h00, 7'h00, 7'h00, 16'h0000, 3'h7);
    hit(18'h3ffff, 16'h0000, 4'h0, 12'h000);
    hit(18'h00300, 16'h0000, 4'h0, 12'h400);
    // Clock enable low freezes the match pulse and drops the read strobe
    @(posedge clk_sys);
    {go, addr, data, rnw, byt} <= {1'b1, 18'h00300, 16'h0000, 2'b00};
    @(posedge clk_sys);
    {go, clk_en, reg_addr, reg_rd} <= {1'b0, 1'b0, 8'h08, 1'b1};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check("match_frozen", 32'h00000400, {21'h000000, fm, 1'b0, tm, 1'b0, bk});
    check("rdata_frozen", 32'h00000000, rdata);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    #1 check("match_held", 32'h00000400, {21'h000000, fm, 1'b0, tm, 1'b0, bk});
    @(posedge clk_sys);
    #1 check("match_thawed", 32'h00000000, {21'h000000, fm, 1'b0, tm, 1'b0, bk});
    report_and_stop();
  end
endmodule
